/* File: logic/mmtmr_top.v */
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "mmtmr_regs.vh"

module mmtmr_top (
	input  wire        clock,
	input  wire        nrst,
	input  wire [5:0]  channelEventInputPin,
	input  wire        subClock,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         irq
);

	// ======================================================
	// State.
	reg  [2:0]  div8_q;
	reg  [4:0]  div32_q;
	reg  [4:0]  subDiv_q;
	reg         subPrev_q;
	reg  [5:0]  pinPrev_q;
	reg  [15:0] cnt_q    [0:5];
	reg  [15:0] reload_q [0:5];
	reg  [7:0]  mode_q   [0:5];
	reg  [5:0]  start_q;
	reg  [5:0]  firstSeen_q;
	reg  [5:0]  ovfPulse_q;
	reg  [5:0]  irqStat_q;
	reg  [5:0]  irqMask_q;
	reg  [7:0]  awAddr_q;
	reg         awHeld_q;
	reg  [31:0] wData_q;
	reg  [3:0]  wStrb_q;
	reg         wHeld_q;
	integer     i;

	// ======================================================
	// Count sources and pin edges. Every source is a one-cycle
	// strobe on the system clock, not a derived clock, so the
	// whole block stays in one clock domain. The sub-clock is
	// sampled like any pin, so it must run well below half the
	// system clock or some of its rising edges are lost.
	wire tick1   = 1'b1;
	wire tick8   = (div8_q == `MMTMR_DIV8_LAST);
	wire tick32  = (div32_q == `MMTMR_DIV32_LAST);
	wire subRise = subClock & ~subPrev_q;
	wire tickS32 = subRise & (subDiv_q == `MMTMR_DIV32_LAST);
	// A pin level must stand for a full cycle to be seen at all.
	wire [5:0] pinRise = channelEventInputPin & ~pinPrev_q;
	wire [5:0] pinFall = ~channelEventInputPin & pinPrev_q;
	// A write is applied once both halves are held and the last
	// answer has been taken by the master.
	wire doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

	// ======================================================
	// Helpers.

	// Channel slot of an address, valid when chanHit says so.
	function [2:0] chanOf;
		input [7:0] a;
		begin
			chanOf = a[5:3] - `MMTMR_CHAN_BASE;
		end
	endfunction

	function chanHit;
		input [7:0] a;
		begin
			chanHit = (a[7:6] == 2'h0) && (a[1:0] == 2'h0) &&
				(a[5:3] >= `MMTMR_CHAN_BASE);
		end
	endfunction

	function globalHit;
		input [7:0] a;
		begin
			globalHit = (a == `MMTMR_START_ADDR) ||
				(a == `MMTMR_IRQ_STAT_ADDR) ||
				(a == `MMTMR_IRQ_MASK_ADDR);
		end
	endfunction

	// Internal count source chosen by the clock select field.
	function srcTick;
		input [1:0] sel;
		input       t1;
		input       t8;
		input       t32;
		input       ts32;
		begin
			case (sel)
				`MMTMR_CLK_DIV1:  srcTick = t1;
				`MMTMR_CLK_DIV8:  srcTick = t8;
				`MMTMR_CLK_DIV32: srcTick = t32;
				default:          srcTick = ts32;
			endcase
		end
	endfunction

	// Effective pin edge for event counting and measurement.
	function edgeHit;
		input [1:0] sel;
		input       rise;
		input       fall;
		begin
			case (sel)
				`MMTMR_EDGE_FALL: edgeHit = fall;
				`MMTMR_EDGE_RISE: edgeHit = rise;
				default:          edgeHit = rise | fall;
			endcase
		end
	endfunction

	// ======================================================
	// Prescalers. Free running, so a channel started mid-way
	// may see its first divided tick early by up to one period.
	always @(posedge clock) begin
		if (!nrst) begin
			div8_q    <= 3'h0;
			div32_q   <= 5'h0;
			subDiv_q  <= 5'h0;
			subPrev_q <= 1'b0;
			pinPrev_q <= 6'h00;
		end else begin
			div8_q    <= div8_q + 3'h1;
			div32_q   <= div32_q + 5'h1;
			subPrev_q <= subClock;
			pinPrev_q <= channelEventInputPin;
			if (subRise) begin
				subDiv_q <= subDiv_q + 5'h1;
			end
		end
	end

	// ======================================================
	// AXI4-Lite handshake. Address and data are taken in either
	// order; one write and one read are in flight at most.
	always @(posedge clock) begin
		if (!nrst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MMTMR_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `MMTMR_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			awAddr_q      <= 8'h00;
			awHeld_q      <= 1'b0;
			wData_q       <= 32'h00000000;
			wStrb_q       <= 4'h0;
			wHeld_q       <= 1'b0;
		end else begin
			s_axi_awready <= ~awHeld_q & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready  <= ~wHeld_q & ~s_axi_wready & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_q      <= s_axi_awaddr;
				awHeld_q      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_q      <= s_axi_wdata;
				wStrb_q      <= s_axi_wstrb;
				wHeld_q      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (chanHit(awAddr_q) ||
					globalHit(awAddr_q)) ?
					`MMTMR_RESP_OKAY : `MMTMR_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// Reads. The data come from the state at the edge that takes
			// the address, so one answer never mixes two updates.
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `MMTMR_RESP_OKAY;
				s_axi_rdata   <= 32'h00000000;
				if (chanHit(s_axi_araddr)) begin
					if (!s_axi_araddr[2]) begin
						s_axi_rdata[7:0] <= mode_q[chanOf(s_axi_araddr)];
					end else if (mode_q[chanOf(s_axi_araddr)][1:0] ==
						`MMTMR_MODE_MEAS) begin
						s_axi_rdata[15:0] <=
							reload_q[chanOf(s_axi_araddr)];
					end else begin
						s_axi_rdata[15:0] <=
							cnt_q[chanOf(s_axi_araddr)];
					end
				end else if (s_axi_araddr == `MMTMR_START_ADDR) begin
					s_axi_rdata[5:0] <= start_q;
				end else if (s_axi_araddr == `MMTMR_IRQ_STAT_ADDR) begin
					s_axi_rdata[5:0] <= irqStat_q;
				end else if (s_axi_araddr == `MMTMR_IRQ_MASK_ADDR) begin
					s_axi_rdata[5:0] <= irqMask_q;
				end else begin
					s_axi_rresp <= `MMTMR_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ======================================================
	// Channels, software register writes and interrupt status.
	// Hardware sets win over a write-one-to-clear in the same cycle
	// so that no event is lost.
	always @(posedge clock) begin : chanBlock
		reg       tick;
		reg       edgeSeen;
		reg [5:0] irqSet;
		reg [2:0] wc;
		reg       wrCnt;
		reg       wrMode;
		reg [15:0] wVal;
		tick     = 1'b0;
		edgeSeen = 1'b0;
		irqSet   = 6'h00;
		wc       = chanOf(awAddr_q);
		wrCnt    = 1'b0;
		wrMode   = 1'b0;
		wVal     = 16'h0000;
		if (!nrst) begin
			start_q     <= 6'h00;
			firstSeen_q <= 6'h00;
			ovfPulse_q  <= 6'h00;
			irqStat_q   <= 6'h00;
			irqMask_q   <= 6'h00;
			irq         <= 1'b0;
			for (i = 0; i < `MMTMR_NUM_CHAN; i = i + 1) begin
				cnt_q[i]    <= `MMTMR_CNT_RESET;
				reload_q[i] <= `MMTMR_CNT_RESET;
				mode_q[i]   <= `MMTMR_MODE_RESET;
			end
		end else begin
			// Each channel is handled in turn; the temporaries hold only
			// this channel's decisions, and its request bit is gathered
			// into irqSet for the status update below.
			for (i = 0; i < `MMTMR_NUM_CHAN; i = i + 1) begin
				wrCnt  = doWrite && chanHit(awAddr_q) && awAddr_q[2] &&
					(wc == i[2:0]);
				wrMode = doWrite && chanHit(awAddr_q) && !awAddr_q[2] &&
					(wc == i[2:0]) && wStrb_q[0];
				// Byte lanes merge into the 16-bit value.
				wVal[7:0]  = wStrb_q[0] ? wData_q[7:0] :
					reload_q[i][7:0];
				wVal[15:8] = wStrb_q[1] ? wData_q[15:8] :
					reload_q[i][15:8];
				ovfPulse_q[i] <= 1'b0;
				if (wrMode) begin
					// Overflow flag is not loaded from the data; a mode write clears it while the channel is started.
					mode_q[i][4:0] <= wData_q[4:0];
					mode_q[i][7:6] <= wData_q[7:6];
					if (start_q[i]) begin
						mode_q[i][`MMTMR_OVF_BIT] <= 1'b0;
					end
				end
				// Measurement counts up and latches on pin edges; the
				// other two modes share the down counter below.
				if (mode_q[i][1:0] == `MMTMR_MODE_MEAS) begin
					tick = srcTick(mode_q[i][7:6], tick1, tick8,
						tick32, tickS32);
					edgeSeen = edgeHit(mode_q[i][3:2], pinRise[i],
						pinFall[i]);
					if (!start_q[i]) begin
						firstSeen_q[i] <= 1'b0;
					end else if (edgeSeen) begin
						reload_q[i]    <= cnt_q[i];
						cnt_q[i]       <= `MMTMR_CNT_RESET;
						firstSeen_q[i] <= 1'b1;
						irqSet[i]      = firstSeen_q[i];
					end else if (tick) begin
						cnt_q[i] <= cnt_q[i] + 16'h0001;
						if (cnt_q[i] == `MMTMR_CNT_MAX) begin
							irqSet[i] = 1'b1;
							mode_q[i][`MMTMR_OVF_BIT] <= 1'b1;
						end
					end
					// Count writes are dropped here.
				end else begin
					if (mode_q[i][1:0] == `MMTMR_MODE_EVENT) begin
						if (mode_q[i][`MMTMR_EVSRC_BIT]) begin
							// Each link of a chain adds one cycle of
							// delay, so a full ring can never form a
							// combinational loop.
							tick = ovfPulse_q[(i + 5) % 6];
						end else begin
							tick = edgeHit(mode_q[i][3:2], pinRise[i],
								pinFall[i]);
						end
					end else begin
						tick = srcTick(mode_q[i][7:6], tick1, tick8,
							tick32, tickS32);
					end
					firstSeen_q[i] <= 1'b0;
					if (wrCnt) begin
						reload_q[i] <= wVal;
						if (!start_q[i]) begin
							cnt_q[i] <= wVal;
						end
					end
					if (start_q[i] && tick) begin
						if (cnt_q[i] == `MMTMR_CNT_RESET) begin
							// Reload after the zero count: n+1 ticks.
							cnt_q[i]      <= wrCnt ? wVal :
								reload_q[i];
							irqSet[i]     = 1'b1;
							ovfPulse_q[i] <= 1'b1;
						end else begin
							cnt_q[i] <= cnt_q[i] - 16'h0001;
						end
					end
				end
			end
			if (doWrite && wStrb_q[0]) begin
				if (awAddr_q == `MMTMR_START_ADDR) begin
					start_q <= wData_q[5:0];
				end
				if (awAddr_q == `MMTMR_IRQ_MASK_ADDR) begin
					irqMask_q <= wData_q[5:0];
				end
			end
			if (doWrite && wStrb_q[0] &&
				(awAddr_q == `MMTMR_IRQ_STAT_ADDR)) begin
				irqStat_q <= (irqStat_q & ~wData_q[5:0]) | irqSet;
			end else begin
				irqStat_q <= irqStat_q | irqSet;
			end
			irq <= |(irqStat_q & irqMask_q);
		end
	end

endmodule // mmtmr_top

`default_nettype wire

/* File: logic/mmtmr_regs.vh */
`ifndef MMTMR_REGS_VH
`define MMTMR_REGS_VH

// ==========================================================
// Register map, byte addresses on the 8-bit AXI4-Lite address.
`define MMTMR_ADDR_W        8
`define MMTMR_START_ADDR    8'h00
`define MMTMR_IRQ_STAT_ADDR 8'h04
`define MMTMR_IRQ_MASK_ADDR 8'h08
// Channel i: mode at 8'h10 + 8*i, count at 8'h14 + 8*i.
`define MMTMR_CHAN_BASE     3'h2
`define MMTMR_CHAN_LAST     3'h7
`define MMTMR_NUM_CHAN      6

// ==========================================================
// Mode register fields.
`define MMTMR_MODE_LSB      0
`define MMTMR_EDGE_LSB      2
`define MMTMR_EVSRC_BIT     4
`define MMTMR_OVF_BIT       5
`define MMTMR_CLKSEL_LSB    6
`define MMTMR_MODE_RESET    8'h00

// Operating modes.
`define MMTMR_MODE_TIMER    2'h0
`define MMTMR_MODE_EVENT    2'h1
`define MMTMR_MODE_MEAS     2'h2

// Edge selection, shared by event counting and measurement.
`define MMTMR_EDGE_FALL     2'h0
`define MMTMR_EDGE_RISE     2'h1
`define MMTMR_EDGE_BOTH     2'h2

// Internal clock source selection.
`define MMTMR_CLK_DIV1      2'h0
`define MMTMR_CLK_DIV8      2'h1
`define MMTMR_CLK_DIV32     2'h2
`define MMTMR_CLK_SUB32     2'h3

// ==========================================================
// Prescaler terminal counts and count limits.
`define MMTMR_DIV8_LAST     3'h7
`define MMTMR_DIV32_LAST    5'h1F
`define MMTMR_CNT_MAX       16'hFFFF
`define MMTMR_CNT_RESET     16'h0000

// AXI responses.
`define MMTMR_RESP_OKAY     2'h0
`define MMTMR_RESP_SLVERR   2'h2

`endif

/* File: verification/mmtmr_properties.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mmtmr_regs.vh"

// ==========================================================
// Register bus checks, seen from the top module's ports only.
module mmtmr_properties (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	// Answers must stand until the master takes them.
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp unstable");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata unstable");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("bvalid held after taking");
	// A read is answered on the very next edge.
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	// No new request is taken while a response is pending.
	a_write_quiet: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write ready too soon");
	a_read_quiet: assert property (s_axi_rvalid |->
		!s_axi_arready) else $error("read ready too soon");
	a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready) else $error("awready held after taking");
	// A refused read must not leak register contents.
	a_err_zero: assert property (s_axi_rvalid &&
		s_axi_rresp == `MMTMR_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
		else $error("refused read carries data");
endmodule // mmtmr_properties

bind mmtmr_top mmtmr_properties i_props (.clock, .nrst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* File: verification/mmtmr_pulse_src.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// External pulse source feeding every channel input pin.
module mmtmr_pulse_src (
	input  wire logic       clock,
	input  wire logic       run,
	input  wire logic [7:0] halfPeriod,
	output var  logic [5:0] pin
);
	logic [7:0] cnt;

	// Parks low when stopped, so a later start always begins with a rise.
	always @(posedge clock) begin
		if (!run) begin
			cnt <= 8'h00;
			pin <= 6'h00;
		end else if (cnt == halfPeriod - 8'h01) begin
			cnt <= 8'h00;
			pin <= ~pin;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule // mmtmr_pulse_src
`default_nettype wire

/* File: verification/tb_multimode_down_up_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mmtmr_regs.vh"
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin \
	nMismatch++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end

// ==========================================================
// Self-checking bench for the six-channel timer.
module tb_multimode_down_up_timer;
	logic        clock = 1'h0, nrst = 1'h0, subClock = 1'h0, run = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, hold;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [5:0]  pins;
	int          nMismatch = 0, nCompared = 0, cyc = 0;

	// Clocks; the sub-clock toggles each cycle, so it rises every 2 cycles.
	always #4 clock = ~clock;
	always @(posedge clock) subClock <= ~subClock;

	mmtmr_pulse_src i_src (.clock, .run, .halfPeriod(8'h0A), .pin(pins));
	mmtmr_top i_dut (.clock, .nrst, .channelEventInputPin(pins), .subClock,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .irq);

	// Cycle count for intervals; a hang ends the run as a failure.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			nMismatch++;
			stopTest;
		end
	end

	task automatic stopTest;
		if (nMismatch == 0 && nCompared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// A nonzero lag raises bready only after that many edges.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input int lag = 0);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= (lag == 0);
		do begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			lag--;
			if (lag == 0) s_axi_bready <= 1'h1;
		end while (!(s_axi_bvalid && s_axi_bready));
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	// A nonzero lag raises rready only after that many edges.
	task automatic rd(input logic [7:0] a, input int lag = 0);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= (lag == 0);
		do begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			lag--;
			if (lag == 0) s_axi_rready <= 1'h1;
		end while (!(s_axi_rvalid && s_axi_rready));
		resp = s_axi_rresp;
		rdv = s_axi_rdata;
		s_axi_rready <= 1'h0;
	endtask

	// Waits for a fresh rise, so a request cleared late is not seen twice.
	task automatic waitIrq;
		do @(posedge clock); while (irq);
		while (!irq) @(posedge clock);
	endtask

	task automatic tRegs;
		logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h38, 8'h3C};
		foreach (a[i]) begin
			rd(a[i]);
			`CHK("reset value", 32'h0, rdv)
		end
		rd(8'h0C);
		`CHK("unmapped rd", {`MMTMR_RESP_SLVERR, 32'h0}, {resp, rdv})
		wr(8'h0C, 32'h1);
		`CHK("unmapped wr", `MMTMR_RESP_SLVERR, resp)
		rd(8'h08, 4);
		`CHK("late rready", 32'h0, rdv)
		wr(8'h08, 32'h0, 6);
		`CHK("late bready", `MMTMR_RESP_OKAY, resp)
	endtask

	// Runs one channel, times two underflows apart, then masks and halts it.
	task automatic tPeriod(input logic [2:0] ch, input logic [7:0] md,
		input logic [15:0] n, input int ex, input logic [5:0] xs);
		logic [7:0]  ma;
		logic [31:0] b;
		int          t;
		ma = 8'h10 + {2'h0, ch, 3'h0};
		b = 32'h1 << ch;
		wr(ma, {24'h0, md});
		wr(ma + 8'h04, {16'h0, n});
		rd(ma + 8'h04);
		`CHK("count", {16'h0, n}, rdv)
		wr(8'h08, b);
		wr(8'h00, b | {26'h0, xs});
		waitIrq;
		wr(8'h04, b);
		waitIrq;
		t = cyc;
		wr(8'h04, b);
		waitIrq;
		`CHK("interval", ex, cyc - t)
		wr(8'h08, 32'h0);
		repeat (2) @(posedge clock);
		`CHK("masked irq", 1'h0, irq)
		wr(8'h00, 32'h0);
		rd(ma + 8'h04);
		hold = rdv;
		repeat (70) @(posedge clock);
		rd(ma + 8'h04);
		`CHK("halted", hold, rdv)
		wr(8'h04, 32'h3F);
	endtask

	task automatic tMeas;
		wr(8'h20, 32'h06);
		wr(8'h08, 32'h04);
		wr(8'h00, 32'h04);
		run <= 1'h1;
		repeat (22) @(posedge clock);
		rd(8'h04);
		`CHK("first edge", 32'h0, rdv)
		repeat (60) @(posedge clock);
		rd(8'h04);
		`CHK("later edge", 32'h4, rdv)
		rd(8'h24);
		`CHK("period", 32'h13, rdv)
		wr(8'h24, 32'h1234);
		rd(8'h24);
		`CHK("count write", 32'h13, rdv)
		run <= 1'h0;
		wr(8'h00, 32'h0);
	endtask

	// Lets a measuring channel run with no pin edge until it wraps.
	task automatic tOvf;
		wr(8'h04, 32'h3F);
		wr(8'h28, 32'h02);
		wr(8'h08, 32'h08);
		wr(8'h00, 32'h08);
		waitIrq;
		rd(8'h28);
		`CHK("overflow flag", 32'h22, rdv)
		rd(8'h04);
		`CHK("overflow irq", 32'h08, rdv)
		wr(8'h28, 32'h02);
		rd(8'h28);
		`CHK("flag cleared", 32'h02, rdv)
		wr(8'h00, 32'h0);
	endtask

	// Main sequence: reset, registers, timer, event and measure modes.
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		tRegs;
		tPeriod(3'h0, 8'h00, 16'h0013, 20, 6'h00);
		tPeriod(3'h0, 8'h40, 16'h0004, 40, 6'h00);
		tPeriod(3'h0, 8'h80, 16'h0001, 64, 6'h00);
		tPeriod(3'h0, 8'hC0, 16'h0000, 64, 6'h00);
		run <= 1'h1;
		tPeriod(3'h1, 8'h01, 16'h0002, 60, 6'h00);
		tPeriod(3'h1, 8'h05, 16'h0002, 60, 6'h00);
		tPeriod(3'h1, 8'h09, 16'h0002, 30, 6'h00);
		run <= 1'h0;
		wr(8'h10, 32'h00);
		wr(8'h14, 32'h09);
		tPeriod(3'h1, 8'h11, 16'h0002, 30, 6'h01);
		tMeas;
		tOvf;
		stopTest;
	end
endmodule // tb_multimode_down_up_timer
`default_nettype wire
